// ===== bss_pkg.sv
/*
  Constants for the boot source selector: state codes, timing counts,
  line counts, bank limits and the default pull map of the general lines.
  Assumes a 100 MHz system clock.
*/
package bss_pkg;
  // System clock period in picoseconds.
  localparam int unsigned CLK_PERIOD_PS = 10000;
  // Retry window on a disabled storage interface, in milliseconds.
  localparam int unsigned RETRY_MS = 2000;
  // Retry window in clock cycles, rounded down as a longest time.
  localparam longint unsigned RETRY_CYCLES =
    (64'(RETRY_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);
  // Number of general-purpose lines and voltage banks.
  localparam int unsigned NUM_LINES = 54;
  localparam int unsigned NUM_BANKS = 3;
  // Last line of bank 0 and last line of bank 1.
  localparam int unsigned BANK0_LAST = 27;
  localparam int unsigned BANK1_LAST = 45;
  // Lines with no default pull after power-on.
  localparam logic [NUM_LINES-1:0] NO_PULL_MASK = 54'h3000_3000_0000;
  // Default pull direction, one bit per line: 1 is up, 0 is down.
  localparam logic [NUM_LINES-1:0] PULL_UP_MAP = 54'h1C_0000_01FF;
  // Number of alternate functions per line, at least two.
  localparam int unsigned NUM_ALT = 6;
  // Width of the per-line function select.
  localparam int unsigned FSEL_W = 3;
  // Function select codes: plain input and plain output.
  localparam logic [FSEL_W-1:0] FSEL_INPUT = 3'h0;
  localparam logic [FSEL_W-1:0] FSEL_OUTPUT = 3'h1;

  // Boot sequencer states, one-hot.
  typedef enum logic [6:0] {
    BSS_ST_OFF = 7'h01,
    BSS_ST_PROBE = 7'h02,
    BSS_ST_SEARCH = 7'h04,
    BSS_ST_RETRY = 7'h08,
    BSS_ST_RUN_STORAGE = 7'h10,
    BSS_ST_USB_WAIT = 7'h20,
    BSS_ST_USB_RUN = 7'h40
  } bss_state_t;
endpackage

// ===== bss_boot_select.sv
/*
  Boot source selector. Sequences the boot attempt on the primary storage
  interface, falls back to USB device mode, drives the storage re-enable
  pin and owns the power-on pad state and function select of the general
  lines.
  Assumes the storage probe, image search and USB download are carried out
  by other logic that reports results here as synchronous level inputs.
*/
`timescale 1ns/100ps

module bss_boot_select #(
  parameter longint unsigned RETRY_CYCLES = bss_pkg::RETRY_CYCLES,
  parameter int unsigned NUM_LINES = bss_pkg::NUM_LINES
) (
  // Clock, reset and clock enable.
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // Run input from the board; low holds the device in power-down.
  input wire logic run_i,
  // Storage probe results from the storage controller.
  input wire logic storage_ready_i,
  input wire logic storage_fail_i,
  // Image search results on the first partition.
  input wire logic part_is_fat_i,
  input wire logic image_found_i,
  input wire logic image_absent_i,
  // USB download handshake.
  input wire logic usb_code_loaded_i,
  // Software request to re-enable storage after a USB boot.
  input wire logic storage_reenable_req_i,
  // Hot plug detect input, only synchronised and passed on.
  input wire logic hot_plug_detect_input_i,
  // Per-line function select, output data and interrupt enable from software, and pad input levels.
  input wire logic [NUM_LINES*bss_pkg::FSEL_W-1:0] line_fsel_i,
  input wire logic [NUM_LINES-1:0] line_out_i,
  input wire logic [NUM_LINES-1:0] line_irq_en_i,
  input wire logic [NUM_LINES-1:0] line_pad_i,
  // Storage sequencing requests.
  output logic storage_probe_o,
  output logic image_search_o,
  output logic image_execute_o,
  // USB role: high selects device role awaiting boot code.
  output logic usb_device_mode_o,
  // Storage re-enable pin: output, output enable, pull-up enable.
  output logic storage_reenable_output_o,
  output logic storage_reenable_output_oe_o,
  output logic storage_reenable_output_pu_o,
  // Hot plug detect as seen by the core.
  output logic hot_plug_o,
  // General line pads: data, enable, pull enable, pull direction.
  output logic [NUM_LINES-1:0] line_o,
  output logic [NUM_LINES-1:0] line_oe_o,
  output logic [NUM_LINES-1:0] line_pull_en_o,
  output logic [NUM_LINES-1:0] line_pull_up_o,
  // Input change interrupt and bank indication.
  output logic line_irq_o,
  output logic [1:0] line_bank_o [NUM_LINES]
);

  // Bank number of a line, used by the bank indication logic.
  function automatic logic [1:0] bank_of(input int unsigned idx);
    if (idx <= bss_pkg::BANK0_LAST) begin
      bank_of = 2'h0;
    end else if (idx <= bss_pkg::BANK1_LAST) begin
      bank_of = 2'h1;
    end else begin
      bank_of = 2'h2;
    end
  endfunction

  // Sequencer state and retry counter.
  bss_pkg::bss_state_t state, next_state;
  logic [63:0] retry_cnt, next_retry_cnt;
  // Registered outputs of the sequencer.
  logic probe, next_probe;
  logic search, next_search;
  logic execute, next_execute;
  logic usb_dev, next_usb_dev;
  logic reen_oe, next_reen_oe;
  // Pull-up of the re-enable pin, kept in its own flop so the pin
  // control comes straight from a register like the output enable.
  logic reen_pu, next_reen_pu;
  // Pad side state.
  logic [NUM_LINES-1:0] pad_o, next_pad_o;
  logic [NUM_LINES-1:0] pad_oe, next_pad_oe;
  logic [NUM_LINES-1:0] pad_pen, next_pad_pen;
  logic [NUM_LINES-1:0] pad_pup, next_pad_pup;
  logic [NUM_LINES-1:0] pad_prev, next_pad_prev;
  logic irq, next_irq;
  logic hpd, next_hpd;
  logic [1:0] bank_r [NUM_LINES];

  // Boot sequencer next-state logic. The retry timeout is a longest time,
  // so a storage that appears late but inside the window still boots.
  always_comb begin
    next_state = state;
    next_retry_cnt = retry_cnt;
    next_probe = 1'b0;
    next_search = 1'b0;
    next_execute = execute;
    next_usb_dev = usb_dev;
    next_reen_oe = reen_oe;
    if (!run_i) begin
      // Held in power-down; release restarts the attempt.
      next_state = bss_pkg::BSS_ST_OFF;
      next_retry_cnt = 64'h0;
      next_execute = 1'b0;
      next_usb_dev = 1'b0;
      next_reen_oe = 1'b0;
    end else begin
      case (state)
        bss_pkg::BSS_ST_OFF: begin
          next_state = bss_pkg::BSS_ST_PROBE;
          next_probe = 1'b1;
        end
        bss_pkg::BSS_ST_PROBE: begin
          if (storage_ready_i) begin
            next_state = bss_pkg::BSS_ST_SEARCH;
            next_search = 1'b1;
          end else if (storage_fail_i) begin
            // A disabled command line shows up as a failed probe.
            next_state = bss_pkg::BSS_ST_RETRY;
          end else begin
            next_probe = 1'b1;
          end
        end
        bss_pkg::BSS_ST_RETRY: begin
          // The window counts failed probes rather than clock cycles, so a
          // storage that is slow to answer stretches it; each retry costs
          // at least two cycles.
          if (retry_cnt >= RETRY_CYCLES - 64'h1) begin
            next_state = bss_pkg::BSS_ST_USB_WAIT;
            next_usb_dev = 1'b1;
          end else begin
            next_retry_cnt = retry_cnt + 64'h1;
            next_state = bss_pkg::BSS_ST_PROBE;
            next_probe = 1'b1;
          end
        end
        bss_pkg::BSS_ST_SEARCH: begin
          if (image_found_i || image_absent_i) begin
            // Decide only once the search has answered; the file system
            // flag means nothing before that.
            if (image_found_i && part_is_fat_i) begin
              // A valid image runs; USB is never entered.
              next_state = bss_pkg::BSS_ST_RUN_STORAGE;
              next_execute = 1'b1;
            end else begin
              // Missing image or a partition that is not FAT.
              next_state = bss_pkg::BSS_ST_USB_WAIT;
              next_usb_dev = 1'b1;
            end
          end else begin
            next_search = 1'b1;
          end
        end
        bss_pkg::BSS_ST_RUN_STORAGE: begin
          next_execute = 1'b1;
        end
        bss_pkg::BSS_ST_USB_WAIT: begin
          // No timeout here: the device waits as long as the host needs,
          // and only a run pulse or reset takes it out again.
          if (usb_code_loaded_i) begin
            next_state = bss_pkg::BSS_ST_USB_RUN;
          end
        end
        bss_pkg::BSS_ST_USB_RUN: begin
          // Only a USB-booted image may drive the pin low.
          if (storage_reenable_req_i) begin
            next_reen_oe = 1'b1;
          end
        end
        default: begin
          next_state = bss_pkg::BSS_ST_OFF;
        end
      endcase
    end
    // The pull-up is on exactly while the pin is not driven.
    next_reen_pu = ~next_reen_oe;
  end

  // Boot sequencer registers.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= bss_pkg::BSS_ST_OFF;
      retry_cnt <= 64'h0;
      probe <= 1'b0;
      search <= 1'b0;
      execute <= 1'b0;
      usb_dev <= 1'b0;
      reen_oe <= 1'b0;
      reen_pu <= 1'b1;
    end else if (clk_en_i) begin
      state <= next_state;
      retry_cnt <= next_retry_cnt;
      reen_pu <= next_reen_pu;
      probe <= next_probe;
      search <= next_search;
      execute <= next_execute;
      usb_dev <= next_usb_dev;
      reen_oe <= next_reen_oe;
    end
  end

  // Pad next-state logic: pulls, direction and input interrupt per line.
  always_comb begin
    logic [bss_pkg::FSEL_W-1:0] fsel;
    fsel = '0;
    next_pad_o = pad_o;
    next_pad_oe = pad_oe;
    next_pad_pen = pad_pen;
    next_pad_pup = pad_pup;
    next_pad_prev = line_pad_i;
    next_irq = 1'b0;
    next_hpd = hot_plug_detect_input_i;
    for (int i = 0; i < NUM_LINES; i++) begin
      fsel = line_fsel_i[i*bss_pkg::FSEL_W +: bss_pkg::FSEL_W];
      if (!run_i) begin
        // Power-down: outputs released, power-on pulls kept.
        next_pad_oe[i] = 1'b0;
      end else if (fsel == bss_pkg::FSEL_OUTPUT) begin
        next_pad_o[i] = line_out_i[i];
        next_pad_oe[i] = 1'b1;
      end else if (fsel == bss_pkg::FSEL_INPUT) begin
        next_pad_oe[i] = 1'b0;
        if (line_irq_en_i[i] && (line_pad_i[i] != pad_prev[i])) begin
          next_irq = 1'b1;
        end
      end else begin
        // Alternate functions: pad output enable released; no peripheral drives the pad here.
        next_pad_oe[i] = 1'b0;
      end
    end
  end

  // Pad registers; power-on pull map loaded at reset.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pad_o <= '0;
      pad_oe <= '0;
      pad_pen <= ~bss_pkg::NO_PULL_MASK;
      pad_pup <= bss_pkg::PULL_UP_MAP;
      pad_prev <= '0;
      irq <= 1'b0;
      hpd <= 1'b0;
    end else if (clk_en_i) begin
      pad_o <= next_pad_o;
      pad_oe <= next_pad_oe;
      pad_pen <= next_pad_pen;
      pad_pup <= next_pad_pup;
      pad_prev <= next_pad_prev;
      irq <= next_irq;
      hpd <= next_hpd;
    end
  end

  // Bank indication per line, held in flip-flops; reset loads bank 0 for every line until the first enabled clock.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        bank_r[i] <= 2'h0;
      end
    end else if (clk_en_i) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        bank_r[i] <= bank_of(i);
      end
    end
  end

  // Output wiring; every output but storage_reenable_output_o, tied low, comes straight from a flip-flop.
  assign storage_probe_o = probe;
  assign image_search_o = search;
  assign image_execute_o = execute;
  assign usb_device_mode_o = usb_dev;
  assign storage_reenable_output_o = 1'b0;
  assign storage_reenable_output_oe_o = reen_oe;
  assign storage_reenable_output_pu_o = reen_pu;
  assign hot_plug_o = hpd;
  assign line_o = pad_o;
  assign line_oe_o = pad_oe;
  assign line_pull_en_o = pad_pen;
  assign line_pull_up_o = pad_pup;
  assign line_irq_o = irq;
  assign line_bank_o = bank_r;

endmodule

// ===== bss_boot_select_properties.sv
/* Port checker for the boot source selector.
   Assumes clk_en_i is held high and reset is bound from the design. */
`timescale 1ns/100ps
module bss_boot_select_properties #(
  parameter longint unsigned RETRY_CYCLES = 8,
  parameter int unsigned NUM_LINES = 54
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Inputs that cause the boot steps.
  input wire logic run_i,
  input wire logic storage_ready_i,
  input wire logic storage_fail_i,
  input wire logic part_is_fat_i,
  input wire logic image_found_i,
  input wire logic image_absent_i,
  input wire logic storage_reenable_req_i,
  // Outputs under watch.
  input wire logic storage_probe_o,
  input wire logic image_search_o,
  input wire logic image_execute_o,
  input wire logic usb_device_mode_o,
  input wire logic storage_reenable_output_o,
  input wire logic storage_reenable_output_oe_o,
  input wire logic storage_reenable_output_pu_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  boot_starts_a: assert property ($rose(run_i) |-> ##[1:3] storage_probe_o)
    else $error("no probe after run release");
  search_cause_a: assert property ($rose(image_search_o) |-> $past(storage_ready_i))
    else $error("search without a ready storage");
  exec_cause_a: assert property ($rose(image_execute_o) |-> $past(image_found_i && part_is_fat_i))
    else $error("execute without an image on a FAT partition");
  exec_not_usb_a: assert property (image_execute_o |-> !usb_device_mode_o)
    else $error("USB role while running from storage");
  absent_usb_a: assert property (image_search_o && image_absent_i |-> ##[1:2] usb_device_mode_o)
    else $error("no USB role after missing image");
  retry_bound_a: assert property (storage_probe_o && storage_fail_i |-> ##[1:60] usb_device_mode_o)
    else $error("retries on dead storage never ended");
  reen_cause_a: assert property ($rose(storage_reenable_output_oe_o) |-> $past(storage_reenable_req_i) && usb_device_mode_o)
    else $error("re-enable driven without USB boot and request");
  reen_idle_a: assert property (!usb_device_mode_o |-> storage_reenable_output_pu_o && !storage_reenable_output_oe_o)
    else $error("re-enable pin not a pulled-up input");
  reen_low_a: assert property (storage_reenable_output_oe_o |-> !storage_reenable_output_o && !storage_reenable_output_pu_o)
    else $error("re-enable pin driven but not low");
  power_down_a: assert property (!run_i [*2] |-> !image_execute_o && !usb_device_mode_o && !storage_reenable_output_oe_o)
    else $error("activity while run is low");
  cover property (image_execute_o);
  cover property ($rose(usb_device_mode_o));
  cover property ($rose(storage_reenable_output_oe_o));
endmodule

bind bss_boot_select bss_boot_select_properties #(.RETRY_CYCLES(RETRY_CYCLES), .NUM_LINES(NUM_LINES))
  chk_u (.clk_sys_i, .resetn_i, .run_i, .storage_ready_i, .storage_fail_i, .part_is_fat_i,
  .image_found_i, .image_absent_i, .storage_reenable_req_i, .storage_probe_o, .image_search_o,
  .image_execute_o, .usb_device_mode_o, .storage_reenable_output_o,
  .storage_reenable_output_oe_o, .storage_reenable_output_pu_o);

// ===== bss_partner.sv
/* Behavioural storage card and USB host facing the boot selector.
   Assumes the bench sets mode and speed while run is low. */
`timescale 1ns/100ps
module bss_partner (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Mode: 0 image, 1 no image, 2 storage cut off, 3 not FAT.
  input wire logic [1:0] mode_i,
  input wire logic slow_i,
  // Requests from the selector.
  input wire logic probe_i,
  input wire logic search_i,
  input wire logic usb_i,
  input wire logic reen_i,
  // Answers to the selector.
  output logic ready_o,
  output logic fail_o,
  output logic fat_o,
  output logic found_o,
  output logic absent_o,
  output logic loaded_o
);
  // Cycles on the current request and the request seen last.
  logic [2:0] cnt;
  logic [2:0] last;
  logic done;
  // A new request restarts the count, so a slow answer is late every time.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 3'h0;
      last <= 3'h0;
    end else begin
      last <= {probe_i, search_i, usb_i};
      cnt <= ({probe_i, search_i, usb_i} != last) ? 3'h0 : cnt + {2'h0, cnt != 3'h7};
    end
  end
  assign done = ({probe_i, search_i, usb_i} == last) && (cnt >= (slow_i ? 3'h4 : 3'h0));
  // Grounded disable line cuts the command line until re-enable drives low.
  assign fail_o = probe_i && done && (mode_i == 2'h2) && !reen_i;
  assign ready_o = probe_i && done && (mode_i != 2'h2);
  // First partition file system and image presence.
  assign fat_o = search_i && done && (mode_i != 2'h3);
  assign found_o = search_i && done && (mode_i == 2'h0 || mode_i == 2'h3);
  assign absent_o = search_i && done && (mode_i != 2'h0);
  // The host loads boot code once the device role appears.
  assign loaded_o = usb_i && done;
endmodule

// ===== bss_boot_select_tb.sv
/* Self-checking bench for the boot selector with its storage and host model.
   Assumes a 100 MHz clock and a retry window shortened to 8. */
`timescale 1ns/100ps
module bss_boot_select_tb;
  localparam longint unsigned RETRY_SIM = 8;
  // Design inputs driven by the bench.
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic run_i = 1'b1;
  logic storage_reenable_req_i = 1'b0;
  logic hot_plug_detect_input_i = 1'b0;
  logic [161:0] line_fsel_i = '0;
  logic [53:0] line_out_i = '0;
  logic [53:0] line_irq_en_i = '0;
  // Pads held at a defined level, as board pulls keep lines 28, 29, 44 and 45.
  logic [53:0] line_pad_i = '0;
  logic [1:0] mode = 2'h0;
  logic slow = 1'b0;
  // Model answers and design outputs.
  logic storage_ready_i, storage_fail_i, part_is_fat_i, image_found_i, image_absent_i;
  logic usb_code_loaded_i, storage_probe_o, image_search_o, image_execute_o;
  logic usb_device_mode_o, storage_reenable_output_o, storage_reenable_output_oe_o;
  logic storage_reenable_output_pu_o, hot_plug_o, line_irq_o;
  logic [53:0] line_o, line_oe_o, line_pull_en_o, line_pull_up_o;
  logic [1:0] line_bank_o [54];
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  bss_boot_select #(.RETRY_CYCLES(RETRY_SIM)) dut_u (.clk_sys_i, .resetn_i, .clk_en_i, .run_i,
    .storage_ready_i, .storage_fail_i, .part_is_fat_i, .image_found_i, .image_absent_i,
    .usb_code_loaded_i, .storage_reenable_req_i, .hot_plug_detect_input_i, .line_fsel_i,
    .line_out_i, .line_irq_en_i, .line_pad_i, .storage_probe_o, .image_search_o,
    .image_execute_o, .usb_device_mode_o, .storage_reenable_output_o,
    .storage_reenable_output_oe_o, .storage_reenable_output_pu_o, .hot_plug_o, .line_o,
    .line_oe_o, .line_pull_en_o, .line_pull_up_o, .line_irq_o, .line_bank_o);
  bss_partner partner_u (.clk_sys_i, .resetn_i, .mode_i(mode), .slow_i(slow),
    .probe_i(storage_probe_o), .search_i(image_search_o), .usb_i(usb_device_mode_o),
    .reen_i(storage_reenable_output_oe_o), .ready_o(storage_ready_i),
    .fail_o(storage_fail_i), .fat_o(part_is_fat_i), .found_o(image_found_i),
    .absent_o(image_absent_i), .loaded_o(usb_code_loaded_i));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Samples land on the falling edge, away from the driving edge.
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // Power down, release run, and see which source the selector settles on.
  task automatic t_boot(input logic [1:0] m, input logic s);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    run_i <= 1'b0;
    mode <= m;
    slow <= s;
    tick(3);
    check("down exec", image_execute_o, 1'b0);
    check("down usb", usb_device_mode_o, 1'b0);
    @(posedge clk_sys_i);
    run_i <= 1'b1;
    tick(1);
    while (image_execute_o !== 1'b1 && usb_device_mode_o !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    tick(5);
    check("exec", image_execute_o, m == 2'h0);
    check("usb role", usb_device_mode_o, m != 2'h0);
    if (m == 2'h2) check("retry span", n >= RETRY_SIM, 1'b1);
  endtask
  // Request storage back; only honoured after a USB boot.
  task automatic t_reen(input logic exp);
    check("pin idle", storage_reenable_output_pu_o, 1'b1);
    @(posedge clk_sys_i);
    storage_reenable_req_i <= 1'b1;
    tick(3);
    check("pin drive", storage_reenable_output_oe_o, exp);
    check("pin pull", storage_reenable_output_pu_o, !exp);
    check("pin level", storage_reenable_output_o, 1'b0);
    @(posedge clk_sys_i);
    storage_reenable_req_i <= 1'b0;
  endtask
  // Plain output, input change interrupt and hot plug pass-through.
  task automatic t_gpio();
    int pulses;
    pulses = 0;
    @(posedge clk_sys_i);
    line_fsel_i[9 +: 3] <= bss_pkg::FSEL_OUTPUT;
    line_out_i[3] <= 1'b1;
    line_irq_en_i[5] <= 1'b1;
    hot_plug_detect_input_i <= 1'b1;
    tick(4);
    check("out enable", line_oe_o[3], 1'b1);
    check("out value", line_o[3], 1'b1);
    check("hot plug", hot_plug_o, 1'b1);
    @(posedge clk_sys_i);
    line_pad_i[5] <= 1'b1;
    repeat (8) begin
      tick(1);
      pulses += (line_irq_o === 1'b1);
    end
    check("irq pulses", pulses, 1);
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    logic [53:0] bare;
    bare = '0;
    bare[28] = 1'b1;
    bare[29] = 1'b1;
    bare[44] = 1'b1;
    bare[45] = 1'b1;
    tick(6);
    check("pull enable", line_pull_en_o, 54'(~bare));
    check("pull dir", line_pull_up_o, bss_pkg::PULL_UP_MAP);
    check("reset pin", storage_reenable_output_oe_o, 1'b0);
    @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    tick(3);
    for (int i = 0; i < 54; i++) begin
      check("bank", line_bank_o[i], (i <= 27) ? 2'h0 : (i <= 45) ? 2'h1 : 2'h2);
    end
    t_boot(2'h0, 1'b0);
    t_reen(1'b0);
    t_boot(2'h0, 1'b1);
    t_boot(2'h1, 1'b0);
    t_reen(1'b1);
    t_boot(2'h3, 1'b1);
    t_boot(2'h2, 1'b0);
    t_reen(1'b1);
    t_gpio();
    test_done();
  end
endmodule
